// ---- hdl/ffdc_pkg.sv ----
// ffdc_pkg: constants, encodings, states and carriers of the fault and
// drive control block.
// assumes a single 10 MHz clock; analog comparators arrive as digital flags.
package ffdc_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ           = 10_000_000;
    localparam int unsigned MAX_PERIOD_NS    = 75_000;
    // longest period rounds down to whole cycles
    localparam int unsigned MAX_PERIOD_CYC   = (MAX_PERIOD_NS / 100 * (CLK_HZ / 10_000_000));
    localparam int unsigned FSW_45K_HZ       = 45_000;
    localparam int unsigned FSW_65K_HZ       = 65_000;
    localparam int unsigned FSW_75K_HZ       = 75_000;
    localparam int unsigned PER_45K_CYC      = CLK_HZ / FSW_45K_HZ;
    localparam int unsigned PER_65K_CYC      = CLK_HZ / FSW_65K_HZ;
    localparam int unsigned PER_75K_CYC      = CLK_HZ / FSW_75K_HZ;
    localparam int unsigned CNT_W            = 10;

    // base drive
    localparam logic [4:0]  MULT_MIN         = 5'h0a;
    localparam logic [4:0]  MULT_MAX         = 5'h1f;
    localparam logic [4:0]  MULT_RST         = 5'h0a;
    localparam logic [6:0]  FIXED_GAIN       = 7'h64;

    // cable compensation options in millivolts
    localparam logic [8:0]  CABLE_0_MV       = 9'h000;
    localparam logic [8:0]  CABLE_150_MV     = 9'h096;
    localparam logic [8:0]  CABLE_337_MV     = 9'h151;
    localparam logic [8:0]  CABLE_412_MV     = 9'h19c;

    // soft start: on-time grows by this many cycles each pulse
    localparam logic [CNT_W-1:0] SOFT_STEP   = 10'h004;
    localparam logic [CNT_W-1:0] SOFT_INIT   = 10'h004;

    typedef enum logic [1:0] {
        FFDC_FSW_45K = 2'h0,
        FFDC_FSW_65K = 2'h1,
        FFDC_FSW_75K = 2'h2
    } ffdc_fsw_t;

    typedef enum logic [1:0] {
        FFDC_CC_0   = 2'h0,
        FFDC_CC_150 = 2'h1,
        FFDC_CC_337 = 2'h2,
        FFDC_CC_412 = 2'h3
    } ffdc_cable_t;

    // gray along lockout -> soft -> run; fault off the path
    typedef enum logic [1:0] {
        FFDC_LOCKOUT = 2'b00,
        FFDC_SOFT    = 2'b01,
        FFDC_RUN     = 2'b11,
        FFDC_FAULT   = 2'b10
    } ffdc_state_t;

    typedef enum logic [1:0] {
        FFDC_PH_IDLE = 2'b00,
        FFDC_PH_ON   = 2'b01,
        FFDC_PH_OFF  = 2'b11
    } ffdc_phase_t;

    // product options
    typedef struct packed {
        ffdc_fsw_t   fsw;
        ffdc_cable_t cable;
        logic        no_input_ov;
    } ffdc_opt_t;

    // comparator flags from the analog front end
    typedef struct packed {
        logic line_uv;
        logic line_ov;
        logic out_uv;
        logic out_ov;
        logic sense_short;
    } ffdc_aux_winding_sense_t;

    // latched fault causes
    typedef struct packed {
        logic period;
        logic line;
        logic output_v;
        logic sense_short;
    } ffdc_fault_t;

    // period length for the fixed frequency option
    function automatic logic [CNT_W-1:0] ffdc_period(input ffdc_fsw_t f);
        unique case (f)
            FFDC_FSW_45K: ffdc_period = CNT_W'(PER_45K_CYC);
            FFDC_FSW_65K: ffdc_period = CNT_W'(PER_65K_CYC);
            FFDC_FSW_75K: ffdc_period = CNT_W'(PER_75K_CYC);
            default:      ffdc_period = CNT_W'(PER_45K_CYC);
        endcase
    endfunction : ffdc_period

    // full-load cable offset in mV
    function automatic logic [8:0] ffdc_cable_mv(input ffdc_cable_t c);
        unique case (c)
            FFDC_CC_0:   ffdc_cable_mv = CABLE_0_MV;
            FFDC_CC_150: ffdc_cable_mv = CABLE_150_MV;
            FFDC_CC_337: ffdc_cable_mv = CABLE_337_MV;
            FFDC_CC_412: ffdc_cable_mv = CABLE_412_MV;
        endcase
    endfunction : ffdc_cable_mv

endpackage : ffdc_pkg

// ---- hdl/ffdc_top.sv ----
// ffdc_top: pulse timing, protection state and base drive setting for a
// primary-side flyback controller.
// assumes all comparator flags are synchronous to mclk; supply lockout
// comes from the analog supervisor as a level.
`timescale 1ns/100ps

// Notes on behaviour
// RULE_01 - aux falling edge checked each cycle.
// RULE_02 - no edge: off-time extends, no pulse.
// RULE_03 - period capped at 75 us, shut off at once.
// RULE_04 - line or output UV/OV stops switching.
// RULE_05 - lockout after a stop restarts soft start.
// RULE_06 - retry while a voltage fault persists.
// RULE_07 - sense above 1.2 V cuts drive this cycle.
// RULE_08 - overcurrent does not latch.
// RULE_09 - sense short after start-up shuts down.
// RULE_10 - short present: restarts never reach run.
// RULE_11 - feedback offset grows with load current.
// RULE_12 - multiplier rises with load, clamped 10..31.
// RULE_13 - base current = ref * 100 * multiplier.
// RULE_14 - frequency option 45, 65 or 75 kHz.
// RULE_15 - cable offset option 0/150/337/412 mV.
// RULE_16 - option masks input overvoltage shutdown.
// RULE_17 - lockout resets all, start-up switch off; multiplier, base current and offset keep tracking load.
// RULE_18 - soft start widens pulses gradually.
// RULE_19 - drive off in shutdown until lockout.
// RULE_20 - period counter clears at each on-time start.
module ffdc_top
    import ffdc_pkg::*;
#(
    parameter int unsigned LOAD_W = 8,
    parameter int unsigned FB_W   = 12
) (
    // clock, reset, enable
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire logic              clk_en,
    // product options, static
    input  wire ffdc_opt_t         product_opt,
    // supply supervisor
    input  wire logic              supply_lockout,
    // sense comparators
    input  wire logic              aux_winding_sense,
    input  wire ffdc_aux_winding_sense_t      volt_flags,
    input  wire logic              overcurrent_cutoff,
    // regulation loop inputs
    input  wire logic [CNT_W-1:0]  on_time_req,
    input  wire logic [LOAD_W-1:0] load_level,
    input  wire logic [FB_W-1:0]   fb_raw,
    input  wire logic [15:0]       reference_base_current,
    // drive and status
    output logic                   base_drive_q,
    output logic                   startup_switch_en_q,
    output logic                   running_q,
    output logic                   oc_flag_q,
    output ffdc_fault_t            fault_q,
    output logic [4:0]             base_drive_multiplier_q,
    output logic [27:0]            base_drive_current_q,
    output logic [FB_W-1:0]        fb_comp_q
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    ffdc_state_t        state_q;
    ffdc_phase_t        phase_q;
    logic [CNT_W-1:0]   period_cnt_q;
    logic [CNT_W-1:0]   soft_on_q;
    logic               aux_prev_q;
    logic               edge_seen_q;
    logic               oc_cut_q;
    logic [CNT_W-1:0]   on_limit;
    logic [CNT_W-1:0]   fixed_per;
    logic               aux_fall;
    logic               line_fault;
    logic               out_fault;
    logic               period_limit;
    logic               short_fault;
    logic               any_fault;
    logic               switching;
    logic               start_pulse;
    logic               end_on;

    ////////////////////////////////////////////////////////////////////////
    // combinational decode

    assign fixed_per    = ffdc_period(product_opt.fsw);         // RULE_14
    assign aux_fall     = aux_prev_q & ~aux_winding_sense;
    // option-gated line overvoltage
    assign line_fault   = volt_flags.line_uv
                        | (volt_flags.line_ov & ~product_opt.no_input_ov); // RULE_16
    assign out_fault    = volt_flags.out_uv | volt_flags.out_ov;   // RULE_04
    assign period_limit = (phase_q != FFDC_PH_IDLE)
                        && (period_cnt_q >= CNT_W'(MAX_PERIOD_CYC) - 10'h001); // RULE_03
    // short sensed only in on-time, once drive exists
    assign short_fault  = volt_flags.sense_short && (phase_q == FFDC_PH_ON); // RULE_09
    assign any_fault    = line_fault | out_fault | period_limit | short_fault;
    assign switching    = (state_q == FFDC_SOFT) || (state_q == FFDC_RUN);
    // soft start clamps on-time; run uses the loop request
    assign on_limit     = (state_q == FFDC_SOFT && soft_on_q < on_time_req)
                        ? soft_on_q : on_time_req;              // RULE_18
    // new pulse: aux edge seen and fixed period elapsed
    assign start_pulse  = switching && !any_fault
                        && ((phase_q == FFDC_PH_IDLE)
                        || (phase_q == FFDC_PH_OFF && edge_seen_q
                            && period_cnt_q >= fixed_per - 10'h001)); // RULE_01 RULE_02
    assign end_on       = (phase_q == FFDC_PH_ON)
                        && (overcurrent_cutoff || period_cnt_q + 10'h001 >= on_limit);

    ////////////////////////////////////////////////////////////////////////
    // protection state; lockout always wins

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= FFDC_LOCKOUT;
        end else if (clk_en) begin
            if (supply_lockout) begin
                state_q <= FFDC_LOCKOUT;                        // RULE_17 RULE_05
            end else begin
                unique case (state_q)
                    FFDC_LOCKOUT: begin
                        state_q <= line_fault ? FFDC_FAULT : FFDC_SOFT; // RULE_06
                    end
                    FFDC_SOFT: begin
                        if (any_fault) begin
                            state_q <= FFDC_FAULT;
                        end else if (soft_on_q >= on_time_req && start_pulse) begin
                            state_q <= FFDC_RUN;
                        end
                    end
                    FFDC_RUN: begin
                        if (any_fault) begin
                            state_q <= FFDC_FAULT;              // RULE_04 RULE_09
                        end
                    end
                    FFDC_FAULT: begin
                        state_q <= FFDC_FAULT;                  // RULE_19
                    end
                endcase
            end
        end
    end

    // sticky fault causes for status
    always_ff @(posedge mclk) begin
        if (reset) begin
            fault_q <= '0;
        end else if (clk_en) begin
            if (supply_lockout) begin
                fault_q <= '0;
            end else if (switching || state_q == FFDC_LOCKOUT) begin
                fault_q.period      <= fault_q.period | period_limit;
                fault_q.line        <= fault_q.line | line_fault;
                fault_q.output_v    <= fault_q.output_v | (switching & out_fault);
                fault_q.sense_short <= fault_q.sense_short | short_fault; // RULE_10
            end
        end
    end

    // start-up supply switch: off in lockout so the supply recharges
    always_ff @(posedge mclk) begin
        if (reset) begin
            startup_switch_en_q <= 1'b0;
            running_q           <= 1'b0;
        end else if (clk_en) begin
            startup_switch_en_q <= !supply_lockout;             // RULE_17
            running_q           <= !supply_lockout && state_q == FFDC_RUN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse phase and period counter

    always_ff @(posedge mclk) begin
        if (reset) begin
            phase_q      <= FFDC_PH_IDLE;
            period_cnt_q <= '0;
        end else if (clk_en) begin
            if (supply_lockout || !switching || any_fault) begin
                phase_q      <= FFDC_PH_IDLE;                   // RULE_03 RULE_19
                period_cnt_q <= '0;
            end else if (start_pulse) begin
                phase_q      <= FFDC_PH_ON;
                period_cnt_q <= '0;                             // RULE_20
            end else begin
                if (end_on) begin
                    phase_q <= FFDC_PH_OFF;
                end
                period_cnt_q <= period_cnt_q + 10'h001;         // RULE_20
            end
        end
    end

    // aux edge watch, rearmed at every on-time start
    always_ff @(posedge mclk) begin
        if (reset) begin
            aux_prev_q  <= 1'b0;
            edge_seen_q <= 1'b0;
        end else if (clk_en) begin
            aux_prev_q <= aux_winding_sense;
            if (start_pulse || phase_q == FFDC_PH_IDLE) begin
                edge_seen_q <= 1'b0;
            end else if (phase_q == FFDC_PH_OFF && aux_fall) begin
                edge_seen_q <= 1'b1;                            // RULE_01
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // overcurrent: cut this cycle only

    always_ff @(posedge mclk) begin
        if (reset) begin
            oc_cut_q  <= 1'b0;
            oc_flag_q <= 1'b0;
        end else if (clk_en) begin
            if (start_pulse) begin
                oc_cut_q <= 1'b0;                               // RULE_08
            end else if (phase_q == FFDC_PH_ON && overcurrent_cutoff) begin
                oc_cut_q <= 1'b1;                               // RULE_07
            end
            oc_flag_q <= (phase_q == FFDC_PH_ON) && overcurrent_cutoff;
        end
    end

    // soft start width ramp, one step per pulse
    always_ff @(posedge mclk) begin
        if (reset) begin
            soft_on_q <= SOFT_INIT;
        end else if (clk_en) begin
            if (state_q != FFDC_SOFT) begin
                soft_on_q <= SOFT_INIT;
            end else if (start_pulse && soft_on_q < on_time_req) begin
                soft_on_q <= soft_on_q + SOFT_STEP;             // RULE_18
            end
        end
    end

    // base drive: high only during an uncut on-time
    always_ff @(posedge mclk) begin
        if (reset) begin
            base_drive_q <= 1'b0;
        end else if (clk_en) begin
            base_drive_q <= !supply_lockout && switching && !any_fault
                         && (start_pulse || (phase_q == FFDC_PH_ON && !end_on
                             && !oc_cut_q && !overcurrent_cutoff)); // RULE_07 RULE_19
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // base drive multiplier and current, cable offset

    always_ff @(posedge mclk) begin
        logic [5:0] m;
        m = 6'h00;
        if (reset) begin
            base_drive_multiplier_q <= MULT_RST;
        end else if (clk_en) begin
            // top five load bits pick the multiplier, then clamp
            m = {1'b0, load_level[LOAD_W-1 -: 5]};
            if (m < {1'b0, MULT_MIN}) begin
                m = {1'b0, MULT_MIN};
            end else if (m > {1'b0, MULT_MAX}) begin
                m = {1'b0, MULT_MAX};
            end
            base_drive_multiplier_q <= m[4:0];                  // RULE_12
        end
    end

    // product is one cycle behind the multiplier; fine for a slow loop
    always_ff @(posedge mclk) begin
        if (reset) begin
            base_drive_current_q <= '0;
        end else if (clk_en) begin
            base_drive_current_q <= reference_base_current * FIXED_GAIN
                                  * base_drive_multiplier_q; // RULE_13
        end
    end

    // offset = full-load mV * load / full scale, saturating
    always_ff @(posedge mclk) begin
        logic [FB_W+LOAD_W+9:0] sum;
        sum = '0;
        if (reset) begin
            fb_comp_q <= '0;
        end else if (clk_en) begin
            sum = (FB_W+LOAD_W+10)'(ffdc_cable_mv(product_opt.cable) * load_level)
                  >> LOAD_W;                                    // RULE_15
            sum = sum + (FB_W+LOAD_W+10)'(fb_raw);              // RULE_11
            fb_comp_q <= (sum > (FB_W+LOAD_W+10)'({FB_W{1'b1}}))
                       ? {FB_W{1'b1}} : sum[FB_W-1:0];
        end
    end

endmodule : ffdc_top

// ---- test/ffdc_asserts.sv ----
// ffdc_asserts: port-level timing checks for ffdc_top, bound in below.
// assumes mclk is the only clock and reset is synchronous, active high.
`timescale 1ns/100ps
module ffdc_asserts
    import ffdc_pkg::*;
#(
    parameter int unsigned LOAD_W = 8,
    parameter int unsigned FB_W   = 12
) (
    // clock and controls
    input wire logic              mclk,
    input wire logic              reset,
    input wire logic              clk_en,
    input wire ffdc_opt_t         product_opt,
    input wire logic              supply_lockout,
    // sense and loop inputs
    input wire logic              aux_winding_sense,
    input wire ffdc_aux_winding_sense_t      volt_flags,
    input wire logic              overcurrent_cutoff,
    input wire logic [LOAD_W-1:0] load_level,
    input wire logic [FB_W-1:0]   fb_raw,
    input wire logic [15:0]       reference_base_current,
    // outputs under watch
    input wire logic              base_drive_q,
    input wire logic              startup_switch_en_q,
    input wire logic              running_q,
    input wire ffdc_fault_t       fault_q,
    input wire logic [4:0]        base_drive_multiplier_q,
    input wire logic [27:0]       base_drive_current_q,
    input wire logic [FB_W-1:0]   fb_comp_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    int unsigned since_q;
    logic        seen_q;
    logic        edge_q;

    function automatic logic [4:0] mult_exp(input logic [LOAD_W-1:0] ld);
        logic [4:0] t;
        t = ld[LOAD_W-1 -: 5];
        return (t < MULT_MIN) ? MULT_MIN : t;
    endfunction : mult_exp

    // offset scales with load, saturating
    function automatic logic [FB_W-1:0] fb_exp(input logic [FB_W-1:0] fb,
                                               input logic [LOAD_W-1:0] ld,
                                               input ffdc_cable_t c);
        int unsigned s;
        s = (c == FFDC_CC_150) ? 150 : (c == FFDC_CC_337) ? 337 : (c == FFDC_CC_412) ? 412 : 0;
        s = fb + ((s * ld) >> LOAD_W);
        return ((s >> FB_W) != 0) ? '1 : FB_W'(s);
    endfunction : fb_exp

    ////////////////////////////////////////
    // trackers run through freezes; lockout restarts the block
    always_ff @(posedge mclk) begin
        if (reset || supply_lockout) begin
            since_q <= 0;
            seen_q  <= 1'b0;
            edge_q  <= 1'b0;
        end else begin
            since_q <= $rose(base_drive_q) ? 1 : since_q + 1;
            seen_q  <= seen_q | $rose(base_drive_q);
            edge_q  <= $rose(base_drive_q) ? 1'b0
                     : (edge_q | ($fell(aux_winding_sense) && !base_drive_q));
        end
    end

    ////////////////////////////////////////
    period_max_a: assert property (
        $rose(base_drive_q) && seen_q |-> since_q <= MAX_PERIOD_CYC)
        else $error("period too long");
    aux_edge_a: assert property (
        $rose(base_drive_q) && seen_q |-> edge_q)
        else $error("pulse without aux edge");
    fault_drive_a: assert property (
        (|fault_q) && clk_en |=> !base_drive_q)
        else $error("drive in shutdown");
    volt_out_a: assert property (
        (volt_flags.out_uv || volt_flags.out_ov) && clk_en && !supply_lockout
        |-> ##[1:3] fault_q.output_v)
        else $error("output fault missed");
    input_ov_off_a: assert property (
        product_opt.no_input_ov && !volt_flags.line_uv && !fault_q.line |=> !fault_q.line)
        else $error("line ov not masked");
    oc_cut_a: assert property (
        $rose(overcurrent_cutoff) && base_drive_q && clk_en |-> ##[1:2] !base_drive_q)
        else $error("overcurrent not cut");
    short_a: assert property (
        $rose(base_drive_q) && volt_flags.sense_short && clk_en && !supply_lockout
        |-> ##[1:3] fault_q.sense_short)
        else $error("sense short not caught");
    lockout_clear_a: assert property (
        supply_lockout && clk_en |=> !running_q && !base_drive_q && fault_q == '0)
        else $error("lockout not cleared");
    startup_sw_a: assert property (
        clk_en |=> startup_switch_en_q == !$past(supply_lockout))
        else $error("start-up switch wrong");
    mult_track_a: assert property (
        clk_en && !supply_lockout |=> base_drive_multiplier_q == mult_exp($past(load_level)))
        else $error("multiplier wrong");
    base_cur_a: assert property (
        clk_en && !supply_lockout |=> base_drive_current_q ==
        28'($past(reference_base_current) * 100 * $past(base_drive_multiplier_q)))
        else $error("base current wrong");
    fb_offset_a: assert property (
        clk_en && !supply_lockout |=> fb_comp_q ==
        fb_exp($past(fb_raw), $past(load_level), $past(product_opt.cable)))
        else $error("cable offset wrong");
endmodule : ffdc_asserts

bind ffdc_top ffdc_asserts #(.LOAD_W(LOAD_W), .FB_W(FB_W)) u_ffdc_chk (
    .mclk, .reset, .clk_en, .product_opt, .supply_lockout, .aux_winding_sense,
    .volt_flags, .overcurrent_cutoff, .load_level, .fb_raw, .reference_base_current,
    .base_drive_q, .startup_switch_en_q, .running_q, .fault_q,
    .base_drive_multiplier_q, .base_drive_current_q, .fb_comp_q);

// ---- test/ffdc_stage_model.sv ----
// ffdc_stage_model: power stage and sense windings seen from the drive pin.
// assumes the drive is registered on mclk; the aux winding rings after turn-off.
`timescale 1ns/100ps
module ffdc_stage_model #(
    parameter int RING = 20
) (
    // clock and drive
    input  wire logic       mclk,
    input  wire logic       base_drive_q,
    // bench knobs
    input  wire logic       hold_aux,
    input  wire logic [7:0] oc_at,
    // sense outputs
    output logic            aux_winding_sense = 1'b0,
    output logic            overcurrent_cutoff = 1'b0
);
    int on_cnt = 0;
    int off_cnt = 0;

    // aux rises at turn-off, falls after the ring; hold_aux fakes a lost edge
    // overcurrent trips oc_at cycles into a pulse
    always_ff @(posedge mclk) begin
        off_cnt            <= base_drive_q ? 0 : off_cnt + 1;
        on_cnt             <= base_drive_q ? on_cnt + 1 : 0;
        aux_winding_sense  <= !base_drive_q && (hold_aux || off_cnt < RING);
        overcurrent_cutoff <= base_drive_q && oc_at != 8'h00 && on_cnt >= int'(oc_at);
    end
endmodule : ffdc_stage_model

// ---- test/ffdc_top_tb.sv ----
// ffdc_top_tb: self-checking bench for ffdc_top against the stage model.
// assumes the checker is bound in; reset is held for ten cycles.
`timescale 1ns/100ps
module ffdc_top_tb import ffdc_pkg::*;;
    logic         mclk = 1'b0;
    logic         reset = 1'b1;
    logic         clk_en = 1'b1;
    logic         supply_lockout = 1'b0;
    logic         hold_aux = 1'b0;
    logic [7:0]   oc_at = 8'h00;
    logic [7:0]   load_level = 8'h80;
    logic [11:0]  fb_raw = 12'h000;
    logic [15:0]  reference_base_current = 16'h0001;
    logic [9:0]   on_time_req = 10'h028;
    ffdc_opt_t    product_opt = '0;
    ffdc_aux_winding_sense_t volt_flags = '0;
    logic         aux_winding_sense, overcurrent_cutoff, base_drive_q;
    logic         startup_switch_en_q, running_q, oc_flag_q;
    ffdc_fault_t  fault_q;
    logic [4:0]   base_drive_multiplier_q;
    logic [27:0]  base_drive_current_q;
    logic [11:0]  fb_comp_q;
    int           errors = 0;
    int           total_checks = 0;
    int           n, w;

    // 10 MHz
    always #50 mclk = ~mclk;

    ffdc_top dut (.mclk, .reset, .clk_en, .product_opt, .supply_lockout, .aux_winding_sense,
        .volt_flags, .overcurrent_cutoff, .on_time_req, .load_level, .fb_raw,
        .reference_base_current, .base_drive_q, .startup_switch_en_q, .running_q, .oc_flag_q,
        .fault_q, .base_drive_multiplier_q, .base_drive_current_q, .fb_comp_q);
    ffdc_stage_model stage (.mclk, .base_drive_q, .hold_aux, .oc_at, .aux_winding_sense,
        .overcurrent_cutoff);

    ////////////////////////////////////////
    function automatic int per_cyc(input int f);
        return CLK_HZ / (f == 0 ? FSW_45K_HZ : f == 1 ? FSW_65K_HZ : FSW_75K_HZ);
    endfunction : per_cyc
    function automatic logic [3:0] fexp(input int i);
        return (i >= 3) ? 4'h4 : (i >= 1) ? 4'h2 : 4'h1;
    endfunction : fexp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic timed_out();
        errors++;
        conclude();
    endtask : timed_out
    // cycles to the next drive rise, past any pulse in flight
    task automatic wait_rise(output int c);
        c = 0;
        while (base_drive_q === 1'b1 && c < 2000) begin
            @(negedge mclk);
            c++;
        end
        while (base_drive_q !== 1'b1 && c < 2000) begin
            @(negedge mclk);
            c++;
        end
        if (c >= 2000)
            timed_out();
    endtask : wait_rise
    task automatic pulse_width(output int c);
        wait_rise(c);
        c = 0;
        while (base_drive_q === 1'b1 && c < 2000) begin
            @(negedge mclk);
            c++;
        end
        if (c >= 2000)
            timed_out();
    endtask : pulse_width
    task automatic wait_for(input bit run);
        for (int i = 0; i < 4000; i++) begin
            if (run ? running_q === 1'b1 : fault_q !== 4'h0)
                return;
            @(negedge mclk);
        end
        timed_out();
    endtask : wait_for
    // options change under lockout, except the cable option in the random loop
    task automatic lockout(input ffdc_opt_t o);
        @(posedge mclk);
        supply_lockout <= 1'b1;
        product_opt    <= o;
        repeat (2) @(posedge mclk);
        supply_lockout <= 1'b0;
    endtask : lockout

    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h5cc3e52d));
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        @(negedge mclk);
        chk(base_drive_multiplier_q, MULT_RST);
        chk(fault_q, 4'h0);
        // each frequency option: soft start widens, then the period settles
        for (int f = 0; f < 3; f++) begin
            lockout(ffdc_opt_t'({2'(f), 3'h0}));
            pulse_width(w);
            pulse_width(n);
            chk(n > w, 1);
            wait_for(1);
            wait_rise(n);
            wait_rise(n);
            chk(n >= per_cyc(f) && n <= per_cyc(f) + 1, 1);
        end
        // multiplier corners, then a freeze that must hold state
        for (int k = 0; k < 3; k++) begin
            @(posedge mclk);
            clk_en     <= k != 2;
            load_level <= (k == 1) ? 8'hff : 8'h00;
            repeat (3) @(negedge mclk);
            chk(base_drive_multiplier_q, k ? MULT_MAX : MULT_MIN);
        end
        @(posedge mclk);
        clk_en <= 1'b1;
        // random loop data under every cable option
        for (int j = 0; j < 200; j++) begin
            @(posedge mclk);
            load_level             <= 8'($urandom);
            fb_raw                 <= (j == 7) ? 12'hfff : 12'($urandom);
            reference_base_current <= 16'($urandom);
            product_opt.cable      <= ffdc_cable_t'(2'(j / 50));
        end
        // overcurrent cuts the pulse short but never latches
        @(posedge mclk);
        oc_at <= 8'd10;
        pulse_width(w);
        pulse_width(w);
        chk(oc_flag_q, 1);
        chk(w <= 14, 1);
        chk(running_q, 1);
        @(posedge mclk);
        oc_at <= 8'h00;
        pulse_width(w);
        pulse_width(w);
        chk(w > 14, 1);
        chk(oc_flag_q, 0);
        // lost aux edge: off-time stretches to the period limit
        @(posedge mclk);
        hold_aux <= 1'b1;
        wait_for(0);
        chk(fault_q, 4'h8);
        repeat (300) @(negedge mclk);
        chk(base_drive_q, 0);
        @(posedge mclk);
        hold_aux <= 1'b0;
        lockout(product_opt);
        wait_for(1);
        // each voltage fault and the sense short: stop, retry, recover once gone
        for (int i = 4; i >= 0; i--) begin
            @(posedge mclk);
            volt_flags <= ffdc_aux_winding_sense_t'(5'h01 << i);
            wait_for(0);
            chk(fault_q, fexp(i));
            repeat (3) @(negedge mclk);
            chk(base_drive_q, 0);
            lockout(product_opt);
            repeat (800) @(negedge mclk);
            chk(running_q, 0);
            chk(fault_q, fexp(i));
            @(posedge mclk);
            volt_flags <= '0;
            lockout(product_opt);
            wait_for(1);
        end
        // line overvoltage ignored under that option
        lockout(ffdc_opt_t'(5'h01));
        wait_for(1);
        @(posedge mclk);
        volt_flags <= ffdc_aux_winding_sense_t'(5'h08);
        repeat (300) @(negedge mclk);
        chk(running_q, 1);
        chk(fault_q, 4'h0);
        conclude();
    end
endmodule : ffdc_top_tb
